// *** design/cpumg_defs.svh ***
// cpumg_defs.svh: constants of the cpu mode memory access guard.
// assumes a 16-bit byte address space and 8-bit data.
`ifndef CPUMG_DEFS_SVH
`define CPUMG_DEFS_SVH

// ****************************************************************
// hard-wired memory partition
// ****************************************************************
`define CPUMG_FW_ROM_LO 16'h0000
`define CPUMG_FW_ROM_HI 16'h0FFF
`define CPUMG_APP_ROM_LO 16'h1000
`define CPUMG_APP_ROM_HI 16'h3FFF
`define CPUMG_FW_EEP_LO 16'h4000
`define CPUMG_FW_EEP_HI 16'h42FF
`define CPUMG_APP_EEP_LO 16'h4300
`define CPUMG_APP_EEP_HI 16'hBFFF
`define CPUMG_FW_RAM_LO 16'hC000
`define CPUMG_FW_RAM_HI 16'hC7FF
`define CPUMG_APP_RAM_LO 16'hC800
`define CPUMG_APP_RAM_HI 16'hFFFF

// ****************************************************************
// special function register indices
// ****************************************************************
`define CPUMG_SFR_SEG_BASE_LOW 3'h0
`define CPUMG_SFR_SEG_BASE_HIGH 3'h1
`define CPUMG_SFR_WIN_BASE_LOW 3'h2
`define CPUMG_SFR_WIN_BASE_HIGH 3'h3
`define CPUMG_SFR_WIN_SIZE_LOW 3'h4
`define CPUMG_SFR_WIN_SIZE_HIGH 3'h5
`define CPUMG_SFR_RST 8'h00

// ****************************************************************
// segment entry fields and table size
// ****************************************************************
`define CPUMG_ENT_RD 0
`define CPUMG_ENT_WR 1
`define CPUMG_ENT_EX 2
`define CPUMG_ENT_VALID 3
`define CPUMG_SEG_IDX_MSB 15
`define CPUMG_SEG_IDX_LSB 12
`define CPUMG_TBL_DEPTH 16

`endif

// *** design/cpumg_pkg.sv ***
// cpumg_pkg: types shared by the access guard files.
// assumes nothing of its surroundings.
package cpumg_pkg;

    // cpu mode of the requesting code, codes 5..7 are illegal
    typedef enum logic [2:0] {
        CPUMG_BOOT,
        CPUMG_TEST,
        CPUMG_FIRMWARE,
        CPUMG_SYSTEM,
        CPUMG_USER
    } cpumg_mode_t;

    // kind of access
    typedef enum logic [1:0] {
        CPUMG_OP_READ,
        CPUMG_OP_WRITE,
        CPUMG_OP_EXEC
    } cpumg_op_t;

    // memory class of an address
    typedef enum logic [2:0] {
        CPUMG_R_FW_ROM,
        CPUMG_R_APP_ROM,
        CPUMG_R_FW_EEP,
        CPUMG_R_APP_EEP,
        CPUMG_R_FW_RAM,
        CPUMG_R_APP_RAM
    } cpumg_region_t;

endpackage

// *** design/cpumg_seg_mem.sv ***
// cpumg_seg_mem: segment table storage, one write and two read ports.
// assumes a single clock; read data are registered, one cycle late.
`timescale 1ns/1ns
`default_nettype none

module cpumg_seg_mem
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW = 4
)
(
    input wire logic i_sys_clk,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr_a,
    input wire logic [AW-1:0] i_raddr_b,
    output logic [WIDTH-1:0] o_rdata_a,
    output logic [WIDTH-1:0] o_rdata_b
);

    logic [WIDTH-1:0] mem [DEPTH];

    // storage write, no reset so it maps to ram
    always_ff @(posedge i_sys_clk)
    begin
        if (i_we)
        begin
            mem[i_waddr] <= i_wdata;
        end
    end

    // registered read ports
    always_ff @(posedge i_sys_clk)
    begin
        o_rdata_a <= mem[i_raddr_a];
        o_rdata_b <= mem[i_raddr_b];
    end

endmodule
`default_nettype wire

// *** design/cpumg_guard.sv ***
// cpumg_guard: checks each cpu access against mode, partition, firmware
// firewall and segment table, and owns the segmentation registers.
// assumes the cpu holds a request stable only in its request cycle and
// issues it while o_ready is high; all inputs are on i_sys_clk.
// Function
// - partition separates firmware from system and user
// - system mode alone sets ram exchange window
// - integrity routine reaches whole eeprom
// - other firmware confined to firmware eeprom area
// - system mode writes segmentation registers
// - system mode edits table in writable memory
// - user mode cannot touch segmentation registers
// - user edits table where segment grants write
// - reset clears table base, disabling segments
// - partition hard-wired, no register alters it
// - segmentation writes only in system mode
// - attribute register written only by permitted mode
// - fixed attribute register set, others refused
// - table access follows normal memory permissions
// - firmware reaches app ram only inside window
// - user access decided by segment entry bits
`timescale 1ns/1ns
`default_nettype none
`include "cpumg_defs.svh"

module cpumg_guard
    import cpumg_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_req,
    input wire logic i_sfr,
    input wire logic [15:0] i_addr,
    input wire cpumg_op_t i_op,
    input wire cpumg_mode_t i_mode,
    input wire logic i_fw_integrity,
    input wire logic [7:0] i_wdata,
    output logic o_ready,
    output logic o_done,
    output logic o_grant,
    output logic o_violation,
    output logic [7:0] o_rdata,
    output logic o_seg_enabled
);

    // ************************************************************
    // functions
    // ************************************************************

    // partition is fixed in logic, nothing writable moves it
    function automatic cpumg_region_t region_of(input logic [15:0] a);
        cpumg_region_t r;
        r = CPUMG_R_APP_RAM;
        if (a <= `CPUMG_FW_ROM_HI)
            r = CPUMG_R_FW_ROM;
        else if (a <= `CPUMG_APP_ROM_HI)
            r = CPUMG_R_APP_ROM;
        else if (a <= `CPUMG_FW_EEP_HI)
            r = CPUMG_R_FW_EEP;
        else if (a <= `CPUMG_APP_EEP_HI)
            r = CPUMG_R_APP_EEP;
        else if (a <= `CPUMG_FW_RAM_HI)
            r = CPUMG_R_FW_RAM;
        return r;
    endfunction

    // write permission of an attribute register per mode
    function automatic logic sfr_wr_ok(input logic [2:0] s,
                                       input cpumg_mode_t m);
        logic ok;
        ok = 1'b0;
        if (s <= `CPUMG_SFR_WIN_SIZE_HIGH)
            ok = (m == CPUMG_SYSTEM);
        return ok;
    endfunction

    // read permission of an attribute register per mode
    function automatic logic sfr_rd_ok(input logic [2:0] s,
                                       input cpumg_mode_t m);
        logic ok;
        ok = 1'b0;
        if (s <= `CPUMG_SFR_SEG_BASE_HIGH)
            ok = (m == CPUMG_SYSTEM);
        else if (s <= `CPUMG_SFR_WIN_SIZE_HIGH)
            ok = (m == CPUMG_SYSTEM) || (m == CPUMG_FIRMWARE);
        return ok;
    endfunction

    // ************************************************************
    // state and registers
    // ************************************************************
    typedef enum logic {CPUMG_IDLE, CPUMG_LOOK} cpumg_state_t;
    cpumg_state_t state_r;
    logic [7:0] seg_base_low_r;
    logic [7:0] seg_base_high_r;
    logic [7:0] fw_ram_window_base_low_r;
    logic [7:0] fw_ram_window_base_high_r;
    logic [7:0] fw_ram_window_size_low_r;
    logic [7:0] fw_ram_window_size_high_r;
    logic [15:0] addr_r;
    cpumg_op_t op_r;
    cpumg_mode_t mode_r;
    logic sfr_r;
    logic integ_r;
    logic [7:0] wdata_r;
    logic tbl_hit_r;

    logic [15:0] seg_base;
    logic [15:0] win_base;
    logic [16:0] win_end;
    logic seg_en;
    logic [15:0] tbl_off;
    logic tbl_hit;
    logic [7:0] seg_entry;
    logic [7:0] tbl_data;
    cpumg_region_t reg_r;
    logic mem_ok;
    logic allow;
    logic tbl_we;
    logic [7:0] sfr_val;
    logic in_win;

    assign seg_base = {seg_base_high_r, seg_base_low_r};
    assign win_base = {fw_ram_window_base_high_r,
                       fw_ram_window_base_low_r};
    assign win_end = {1'b0, win_base} + {1'b0, fw_ram_window_size_high_r,
                                         fw_ram_window_size_low_r};
    // zero base means no segment is usable at all
    assign seg_en = (seg_base != 16'h0000);

    // table sits in ordinary address space at its base
    assign tbl_off = i_addr - seg_base;
    assign tbl_hit = seg_en && (i_addr >= seg_base)
                     && (tbl_off < 16'(`CPUMG_TBL_DEPTH));

    // ************************************************************
    // segment table storage
    // ************************************************************
    cpumg_seg_mem
    #(
        .WIDTH(8),
        .DEPTH(`CPUMG_TBL_DEPTH),
        .AW(4)
    )
    u_seg_mem
    (
        .i_sys_clk(i_sys_clk),
        .i_we(tbl_we),
        .i_waddr(4'(addr_r - seg_base)),
        .i_wdata(wdata_r),
        .i_raddr_a(i_addr[`CPUMG_SEG_IDX_MSB:`CPUMG_SEG_IDX_LSB]),
        .i_raddr_b(tbl_off[3:0]),
        .o_rdata_a(seg_entry),
        .o_rdata_b(tbl_data)
    );

    // ************************************************************
    // access decision
    // ************************************************************

    // decision for the latched request, seg entry now valid
    always_comb
    begin
        reg_r = region_of(addr_r);
        in_win = ({1'b0, addr_r} >= {1'b0, win_base})
                 && ({1'b0, addr_r} < win_end);
        mem_ok = 1'b0;
        unique case (mode_r)
            CPUMG_BOOT:
            begin
                mem_ok = ((reg_r == CPUMG_R_FW_ROM) && (op_r != CPUMG_OP_WRITE))
                         || (reg_r == CPUMG_R_FW_EEP)
                         || ((reg_r == CPUMG_R_FW_RAM)
                             && (op_r != CPUMG_OP_EXEC));
            end
            CPUMG_TEST:
            begin
                mem_ok = (((reg_r == CPUMG_R_FW_ROM)
                           || (reg_r == CPUMG_R_APP_ROM))
                          && (op_r != CPUMG_OP_WRITE))
                         || (reg_r == CPUMG_R_FW_EEP)
                         || (reg_r == CPUMG_R_APP_EEP)
                         || (((reg_r == CPUMG_R_FW_RAM)
                              || (reg_r == CPUMG_R_APP_RAM))
                             && (op_r != CPUMG_OP_EXEC));
            end
            CPUMG_FIRMWARE:
            begin
                // firewall: only the fw eeprom area unless integrity run
                mem_ok = ((reg_r == CPUMG_R_FW_ROM)
                          && (op_r != CPUMG_OP_WRITE))
                         || (reg_r == CPUMG_R_FW_EEP)
                         || (integ_r && (reg_r == CPUMG_R_APP_EEP)
                             && (op_r != CPUMG_OP_EXEC))
                         || ((reg_r == CPUMG_R_FW_RAM)
                             && (op_r != CPUMG_OP_EXEC))
                         || ((reg_r == CPUMG_R_APP_RAM) && in_win
                             && (op_r != CPUMG_OP_EXEC));
            end
            CPUMG_SYSTEM:
            begin
                // app memories only, firmware areas stay closed
                mem_ok = ((reg_r == CPUMG_R_APP_ROM)
                          && (op_r != CPUMG_OP_WRITE))
                         || (reg_r == CPUMG_R_APP_EEP)
                         || ((reg_r == CPUMG_R_APP_RAM)
                             && (op_r != CPUMG_OP_EXEC));
            end
            CPUMG_USER:
            begin
                // segment entry of the address decides each access
                if (seg_en && seg_entry[`CPUMG_ENT_VALID]
                    && ((reg_r == CPUMG_R_APP_ROM)
                        || (reg_r == CPUMG_R_APP_EEP)
                        || (reg_r == CPUMG_R_APP_RAM)))
                begin
                    unique case (op_r)
                        CPUMG_OP_READ:
                            mem_ok = seg_entry[`CPUMG_ENT_RD];
                        CPUMG_OP_WRITE:
                            mem_ok = seg_entry[`CPUMG_ENT_WR]
                                     && (reg_r != CPUMG_R_APP_ROM);
                        CPUMG_OP_EXEC:
                            mem_ok = seg_entry[`CPUMG_ENT_EX]
                                     && (reg_r != CPUMG_R_APP_RAM);
                        default:
                            mem_ok = 1'b0;
                    endcase
                end
            end
            default:
                mem_ok = 1'b0;
        endcase
        // attribute registers: fixed set, unmapped index refused
        if (sfr_r)
        begin
            if (op_r == CPUMG_OP_WRITE)
                allow = sfr_wr_ok(addr_r[2:0], mode_r);
            else if (op_r == CPUMG_OP_READ)
                allow = sfr_rd_ok(addr_r[2:0], mode_r);
            else
                allow = 1'b0;
        end
        else
        begin
            allow = mem_ok;
        end
    end

    // table content changes only for a permitted write to it
    assign tbl_we = (state_r == CPUMG_LOOK) && !sfr_r && tbl_hit_r
                    && allow && (op_r == CPUMG_OP_WRITE);

    // register read mux
    always_comb
    begin
        unique case (addr_r[2:0])
            `CPUMG_SFR_SEG_BASE_LOW: sfr_val = seg_base_low_r;
            `CPUMG_SFR_SEG_BASE_HIGH: sfr_val = seg_base_high_r;
            `CPUMG_SFR_WIN_BASE_LOW: sfr_val = fw_ram_window_base_low_r;
            `CPUMG_SFR_WIN_BASE_HIGH: sfr_val = fw_ram_window_base_high_r;
            `CPUMG_SFR_WIN_SIZE_LOW: sfr_val = fw_ram_window_size_low_r;
            `CPUMG_SFR_WIN_SIZE_HIGH: sfr_val = fw_ram_window_size_high_r;
            default: sfr_val = `CPUMG_SFR_RST;
        endcase
    end

    // ************************************************************
    // sequencing
    // ************************************************************

    // two-cycle check: latch, then decide with entry read back
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_r <= CPUMG_IDLE;
            addr_r <= 16'h0000;
            op_r <= CPUMG_OP_READ;
            mode_r <= CPUMG_BOOT;
            sfr_r <= 1'b0;
            integ_r <= 1'b0;
            wdata_r <= 8'h00;
            tbl_hit_r <= 1'b0;
        end
        else if (state_r == CPUMG_IDLE)
        begin
            if (i_req && o_ready)
            begin
                state_r <= CPUMG_LOOK;
                addr_r <= i_addr;
                op_r <= i_op;
                mode_r <= i_mode;
                sfr_r <= i_sfr;
                integ_r <= i_fw_integrity;
                wdata_r <= i_wdata;
                tbl_hit_r <= tbl_hit && !i_sfr;
            end
        end
        else
        begin
            state_r <= CPUMG_IDLE;
        end
    end

    // answer outputs, all from flops
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_ready <= 1'b0;
            o_done <= 1'b0;
            o_grant <= 1'b0;
            o_violation <= 1'b0;
            o_rdata <= 8'h00;
        end
        else
        begin
            o_done <= 1'b0;
            o_grant <= 1'b0;
            o_violation <= 1'b0;
            if (state_r == CPUMG_IDLE)
            begin
                // a request seen while ready is low is ignored
                o_ready <= !(i_req && o_ready);
            end
            else
            begin
                o_ready <= 1'b1;
                o_done <= 1'b1;
                // register and table accesses are answered here, no grant
                o_grant <= allow && !sfr_r && !tbl_hit_r;
                o_violation <= !allow;
                // plain memory reads are served outside, no data here
                if (allow && (op_r == CPUMG_OP_READ) && (sfr_r || tbl_hit_r))
                    o_rdata <= sfr_r ? sfr_val : tbl_data;
                else
                    o_rdata <= 8'h00;
            end
        end
    end

    // segmentation registers: clear on reset, system mode writes only
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            seg_base_low_r <= `CPUMG_SFR_RST;
            seg_base_high_r <= `CPUMG_SFR_RST;
            o_seg_enabled <= 1'b0;
        end
        else
        begin
            o_seg_enabled <= seg_en;
            if ((state_r == CPUMG_LOOK) && sfr_r && allow
                && (op_r == CPUMG_OP_WRITE))
            begin
                if (addr_r[2:0] == `CPUMG_SFR_SEG_BASE_LOW)
                    seg_base_low_r <= wdata_r;
                if (addr_r[2:0] == `CPUMG_SFR_SEG_BASE_HIGH)
                    seg_base_high_r <= wdata_r;
            end
        end
    end

    // exchange window registers, owned by system mode
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            fw_ram_window_base_low_r <= `CPUMG_SFR_RST;
            fw_ram_window_base_high_r <= `CPUMG_SFR_RST;
            fw_ram_window_size_low_r <= `CPUMG_SFR_RST;
            fw_ram_window_size_high_r <= `CPUMG_SFR_RST;
        end
        else if ((state_r == CPUMG_LOOK) && sfr_r && allow
                 && (op_r == CPUMG_OP_WRITE))
        begin
            if (addr_r[2:0] == `CPUMG_SFR_WIN_BASE_LOW)
                fw_ram_window_base_low_r <= wdata_r;
            if (addr_r[2:0] == `CPUMG_SFR_WIN_BASE_HIGH)
                fw_ram_window_base_high_r <= wdata_r;
            if (addr_r[2:0] == `CPUMG_SFR_WIN_SIZE_LOW)
                fw_ram_window_size_low_r <= wdata_r;
            if (addr_r[2:0] == `CPUMG_SFR_WIN_SIZE_HIGH)
                fw_ram_window_size_high_r <= wdata_r;
        end
    end

endmodule
`default_nettype wire

// *** bench/cpumg_guard_sva.sv ***
// cpumg_guard_sva: port-level checks of the access guard.
// assumes a bind onto cpumg_guard, one clock, async active-high reset.
`timescale 1ns/1ns
`default_nettype none
module cpumg_guard_sva
    import cpumg_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_req,
    input wire logic i_sfr,
    input wire logic [15:0] i_addr,
    input wire cpumg_op_t i_op,
    input wire cpumg_mode_t i_mode,
    input wire logic i_fw_integrity,
    input wire logic [7:0] i_wdata,
    input wire logic o_ready,
    input wire logic o_done,
    input wire logic o_grant,
    input wire logic o_violation,
    input wire logic [7:0] o_rdata,
    input wire logic o_seg_enabled
);
// ****************
// access checks
// ****************
    logic tk;
    logic mem;
    // a request counts only while ready is high
    assign tk = i_req && o_ready;
    assign mem = tk && !i_sfr;
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    chk_answer_timing: assert property (
        tk |=> !o_ready ##1 (o_done && o_ready))
        else $error("answer not two edges after request");
    chk_grant_clean: assert property (
        o_grant |-> o_done && !o_violation)
        else $error("grant outside a clean answer");
    chk_viol_no_data: assert property (
        o_violation |-> o_rdata == 8'h00)
        else $error("data leaked on a refused access");
    chk_user_sfr_block: assert property (
        tk && i_sfr && i_mode == CPUMG_USER |-> ##2 o_violation)
        else $error("user register access not refused");
    chk_seg_sys_only: assert property (
        tk && i_sfr && i_op == CPUMG_OP_WRITE && i_addr[2:0] < 3'h2
        && i_mode != CPUMG_SYSTEM
        |-> ##2 (o_violation && $stable(o_seg_enabled)))
        else $error("segmentation write outside system mode");
    chk_fixed_reg_set: assert property (
        tk && i_sfr && i_addr[2:0] > 3'h5 |-> ##2 o_violation)
        else $error("reserved register index accepted");
    chk_user_no_seg: assert property (
        mem && i_mode == CPUMG_USER |-> ##2 (o_seg_enabled || o_violation))
        else $error("user access with segments disabled");
    chk_fw_firewall: assert property (
        mem && i_mode == CPUMG_FIRMWARE && !i_fw_integrity
        && i_addr inside {[16'h4300:16'hBFFF]} |-> ##2 o_violation)
        else $error("firmware outside its eeprom area");
    cov_grant: cover property (o_grant);
    cov_violation: cover property (o_violation);
    cov_seg_on: cover property ($rose(o_seg_enabled));
endmodule
`default_nettype wire

// *** bench/cpumg_cpu_model.sv ***
// cpumg_cpu_model: cpu side, one mode-tagged access at a time.
// assumes it is called at a falling edge of i_sys_clk.
`timescale 1ns/1ns
`default_nettype none
module cpumg_cpu_model
    import cpumg_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_ready,
    input wire logic i_done,
    input wire logic i_grant,
    input wire logic i_violation,
    input wire logic [7:0] i_rdata,
    output var logic o_req,
    output var logic o_sfr,
    output var logic [15:0] o_addr,
    output var cpumg_op_t o_op,
    output var cpumg_mode_t o_mode,
    output var logic o_fw_integrity,
    output var logic [7:0] o_wdata
);
// ****************
// request driver
// ****************
    // bus idle from time zero
    initial
    begin
        o_req = 1'b0;
        o_sfr = 1'b0;
        o_addr = 16'h0000;
        o_op = CPUMG_OP_READ;
        o_mode = CPUMG_USER;
        o_fw_integrity = 1'b0;
        o_wdata = 8'h00;
    end
    // hold until taken, then invert released lines so the guard
    // cannot lean on a stale copy
    task automatic access(input logic s, input logic [15:0] a,
        input cpumg_op_t op, input cpumg_mode_t m, input logic fi,
        input logic [7:0] wd, output logic [10:0] res);
        int n;
        n = 0;
        o_req = 1'b1;
        o_sfr = s;
        o_addr = a;
        o_op = op;
        o_mode = m;
        o_fw_integrity = fi;
        o_wdata = wd;
        while (!i_ready && n++ < 16) @(negedge i_sys_clk);
        @(negedge i_sys_clk);
        o_req = 1'b0;
        o_addr = ~a;
        o_fw_integrity = ~fi;
        o_wdata = ~wd;
        // the answer stands one cycle only
        @(negedge i_sys_clk);
        res = {i_done, i_grant, i_violation, i_rdata};
    endtask
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// testbench: drives the access guard through the cpu model and checks
// every answer against a reference model. assumes nothing else.
`timescale 1ns/1ns
`default_nettype none
module testbench
    import cpumg_pkg::*;
;
    logic i_sys_clk;
    logic i_rst;
    logic req, sfr, fi, ready, done, grant, viol, seg_en;
    logic [15:0] addr;
    logic [7:0] wdata, rdata;
    cpumg_op_t op;
    cpumg_mode_t mode;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int k, a, o, sb;
    int regs[6];
    int tbl[16];
    int edge_a[4] = '{16'hCFFF, 16'hD000, 16'hD0FF, 16'hD100};
    cpumg_guard i_cpumg_guard (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_req(req), .i_sfr(sfr), .i_addr(addr), .i_op(op), .i_mode(mode),
        .i_fw_integrity(fi), .i_wdata(wdata), .o_ready(ready),
        .o_done(done), .o_grant(grant), .o_violation(viol),
        .o_rdata(rdata), .o_seg_enabled(seg_en));
    cpumg_cpu_model i_cpumg_cpu_model (.i_sys_clk(i_sys_clk),
        .i_ready(ready), .i_done(done), .i_grant(grant),
        .i_violation(viol), .i_rdata(rdata), .o_req(req), .o_sfr(sfr),
        .o_addr(addr), .o_op(op), .o_mode(mode), .o_fw_integrity(fi),
        .o_wdata(wdata));
// ****************
// helpers
// ****************
    task automatic check(input string nm, input logic [10:0] seen,
        input logic [10:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // reference answer {done, grant, violation, data}; updates state
    function automatic logic [10:0] ref_acc(input int s, a, o, m, fi, wd);
        int mk, rg, e, wb, ws;
        sb = regs[1] * 256 + regs[0];
        wb = regs[3] * 256 + regs[2];
        ws = regs[5] * 256 + regs[4];
        rg = (a >= 16'h1000) + (a >= 16'h4000) + (a >= 16'h4300)
            + (a >= 16'hC000) + (a >= 16'hC800);
        if (s)
        begin
            if (o == 2 || a > 5 || (m != 3 && !(m == 2 && o == 0 && a > 1)))
                return 11'h500;
            if (o == 1) regs[a] = wd;
            return o == 1 ? 11'h400 : {3'b100, 8'(regs[a])};
        end
        // one rwx nibble per region, fw rom in the lowest
        case (m)
            0: mk = 24'h030705;
            1: mk = 24'h337755;
            2: mk = 24'h030705 | (fi ? 24'h003000 : 24'h0)
                | (a >= wb && a < wb + ws ? 24'h300000 : 24'h0);
            default: mk = m < 5 ? 24'h307050 : 24'h0;
        endcase
        mk = (mk >> (4 * rg)) & 15;
        e = tbl[a >> 12];
        if (m == 4) mk = sb != 0 && e[3] ? mk & e : 0;
        if (!mk[o]) return 11'h500;
        if (sb == 0 || a < sb || a >= sb + 16) return 11'h600;
        if (o == 1) tbl[a - sb] = wd;
        return o != 0 ? 11'h400 : {3'b100, 8'(tbl[a - sb])};
    endfunction
    task automatic go(input int s, a, o, m, fi, wd);
        logic [10:0] res;
        i_cpumg_cpu_model.access(s[0], a[15:0], cpumg_op_t'(o[1:0]),
            cpumg_mode_t'(m[2:0]), fi[0], wd[7:0], res);
        check("response", res, ref_acc(s, a, o, m, fi, wd));
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
// ****************
// clock, watchdog and sequence
// ****************
    initial
    begin
        i_sys_clk = 1'b0;
        forever #10 i_sys_clk = ~i_sys_clk;
    end
    // the run needs about seven hundred cycles, so a hang ends it early
    always @(posedge i_sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            wrap_up();
        end
    end
    initial
    begin
        i_rst = 1'b1;
        regs = '{default: 0};
        void'($urandom(32'h18B3));
        repeat (5) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        i_rst = 1'b0;
        check("seg_enabled", {10'h000, seg_en}, 11'h000);
        go(0, 16'h1000, 0, 4, 0, 0);
        // table base high from every mode, then read back
        for (k = 0; k < 5; k++) go(1, 1, 1, k, 0, 8'h80);
        for (k = 0; k < 5; k++) go(1, 1, 0, k, 0, 0);
        check("seg_enabled", {10'h000, seg_en}, 11'h001);
        // fill the table, then open segment 8 to user read and write
        for (k = 0; k < 16; k++) go(0, 16'h8000 + k, 1, 3, 0, $urandom % 256);
        go(0, 16'h8008, 1, 3, 0, 8'h0B);
        go(0, 16'h8003, 1, 4, 0, 8'h5A);
        go(0, 16'h8003, 0, 3, 0, 0);
        go(0, 16'h8004, 2, 4, 0, 0);
        // exchange window D000..D0FF set by system only
        for (k = 2; k < 6; k++) go(1, k, 1, 3, 0, k == 3 ? 8'hD0 : k == 5);
        go(1, 4, 1, 2, 0, 8'h55);
        go(1, 5, 0, 2, 0, 0);
        for (k = 0; k < 4; k++) go(0, edge_a[k], k % 2, 2, 0, k);
        // integrity routine against other firmware code
        for (k = 0; k < 4; k++) go(0, 16'h4300 + k, k / 2, 2, k % 2, k);
        go(0, 16'h42FF, 2, 2, 0, 0);
        go(0, 16'hC000, 1, 3, 0, 0);
        go(1, 6, 0, 3, 0, 0);
        go(1, 7, 1, 3, 0, 0);
        // random traffic over all modes, kinds and regions
        for (k = 0; k < 300; k++)
        begin
            sb = regs[1] * 256 + regs[0];
            a = ($urandom % 4 == 0) ? 16'h8000 + $urandom % 24 : $urandom % 65536;
            o = $urandom % 3;
            // executing a table byte is left open, so keep it out
            if (sb != 0 && a >= sb && a < sb + 16) o = $urandom % 2;
            if ($urandom % 8 == 0)
                go(1, a % 8, o, $urandom % 5, 0, $urandom % 256);
            else
                go(0, a, o, $urandom % 8, $urandom % 2, $urandom % 256);
        end
        // a second reset mid-run must close every segment again
        i_rst = 1'b1;
        regs = '{default: 0};
        @(negedge i_sys_clk);
        i_rst = 1'b0;
        check("seg_enabled", {10'h000, seg_en}, 11'h000);
        go(0, 16'h1000, 0, 4, 0, 0);
        wrap_up();
    end
endmodule
bind cpumg_guard cpumg_guard_sva i_cpumg_guard_sva (.i_sys_clk(i_sys_clk),
    .i_rst(i_rst), .i_req(i_req), .i_sfr(i_sfr), .i_addr(i_addr),
    .i_op(i_op), .i_mode(i_mode), .i_fw_integrity(i_fw_integrity),
    .i_wdata(i_wdata), .o_ready(o_ready), .o_done(o_done),
    .o_grant(o_grant), .o_violation(o_violation), .o_rdata(o_rdata),
    .o_seg_enabled(o_seg_enabled));
`default_nettype wire
